// [src/sspp_pkg.sv]
// Constants shared by the synthesizer serial programming port and its dividers.
package sspp_pkg;
    localparam int SHIFT_W = 24;
    localparam int CTRL_W = 2;
    localparam int NUM_LATCH = 4;
    localparam int REF_W = 14;
    localparam int SWALLOW_W = 6;
    localparam int MAIN_W = 13;
    localparam int PRE_CNT_W = 7;
    localparam int MUX_W = 3;
    localparam int PRE_SEL_W = 2;
    // Positions of the synchronised pins in the sampled pin vector.
    localparam int PIN_NUM = 6;
    localparam int PIN_SCLK = 5;
    localparam int PIN_SDATA = 4;
    localparam int PIN_LOAD = 3;
    localparam int PIN_CE = 2;
    localparam int PIN_REF = 1;
    localparam int PIN_RF = 0;
    // Latch addresses carried by the two control bits.
    localparam logic [1:0] LATCH_REF = 2'h0;
    localparam logic [1:0] LATCH_AB = 2'h1;
    localparam logic [1:0] LATCH_FUNC = 2'h2;
    localparam logic [1:0] LATCH_INIT = 2'h3;
    // Field positions inside the latches.
    localparam int REF_LSB = 2;
    localparam int SWALLOW_LSB = 2;
    localparam int MAIN_LSB = 8;
    localparam int PD_BIT = 3;
    localparam int MUX_LSB = 4;
    localparam int PRE_LSB = 22;
    // Values after reset.
    localparam logic [SHIFT_W-1:0] LATCH_RESET = 24'h000000;
    localparam logic [PIN_NUM-1:0] PIN_RESET = 6'h00;
    // Observation selections.
    localparam logic [MUX_W-1:0] MUX_LOW = 3'h0;
    localparam logic [MUX_W-1:0] MUX_LOCK = 3'h1;
    localparam logic [MUX_W-1:0] MUX_RF_DIV = 3'h2;
    localparam logic [MUX_W-1:0] MUX_REF_DIV = 3'h3;
    // Smallest prescaler modulus; each step of the select doubles it.
    localparam logic [PRE_CNT_W-1:0] PRE_BASE = 7'h08;
endpackage

// [src/sspp_divider.sv]
// Programmable divider that emits one pulse per modulus input ticks.
module sspp_divider #(
    parameter int WIDTH = 14
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic [WIDTH-1:0] i_modulus,
    output logic o_pulse
);
    logic [WIDTH-1:0] cnt;
    wire [WIDTH-1:0] cnt_inc = cnt + 1'b1;
    // A modulus of zero divides by one rather than stalling the comparator.
    wire last = (cnt_inc >= i_modulus);

    // Count ticks and wrap on the last one of each period.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || i_clear) begin
            cnt <= '0;
            o_pulse <= 1'b0;
        end else begin
            o_pulse <= i_tick & last;
            if (i_tick) begin
                cnt <= last ? '0 : cnt_inc;
            end
        end
    end

    a_div_wrap: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_tick && last && !i_clear) |=> o_pulse)
        else $error("divider missed its terminal count");
    a_div_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !i_tick |=> !o_pulse)
        else $error("divider pulsed without an input tick");
endmodule

// [src/sspp_port.sv]
// Serial programming port, latches, dividers and phase comparator of the synthesizer.
module sspp_port (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_load_strobe,
    input wire logic i_chip_enable,
    input wire logic i_reference_input,
    input wire logic i_rf_feedback_input,
    output logic o_pump_up,
    output logic o_pump_dn,
    output logic o_pump_oe,
    output logic o_powered_down,
    output logic o_observe_mux_output
);
    logic [sspp_pkg::PIN_NUM-1:0] pin_meta;
    logic [sspp_pkg::PIN_NUM-1:0] pin_sync;
    logic [sspp_pkg::PIN_NUM-1:0] pin_prev;
    logic [sspp_pkg::SHIFT_W-1:0] shift;
    logic [sspp_pkg::SHIFT_W-1:0] latch [sspp_pkg::NUM_LATCH];
    logic [sspp_pkg::PRE_CNT_W-1:0] pcnt;
    logic [sspp_pkg::SWALLOW_W-1:0] swallow_left;
    logic [sspp_pkg::MAIN_W-1:0] main_left;
    logic fb_pulse;
    logic ref_div_q;
    logic fb_div_q;
    logic lock;
    logic ref_pulse;

    wire [sspp_pkg::PIN_NUM-1:0] pins = {i_sclk, i_sdata, i_load_strobe,
                                         i_chip_enable, i_reference_input,
                                         i_rf_feedback_input};

    // Every pin is asynchronous to the system clock, so all pass two flops first.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            pin_meta <= sspp_pkg::PIN_RESET;
            pin_sync <= sspp_pkg::PIN_RESET;
            pin_prev <= sspp_pkg::PIN_RESET;
        end else begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge detection on the synchronised copies; data and strobe keep equal delay.
    wire sclk_rise = pin_sync[sspp_pkg::PIN_SCLK] & ~pin_prev[sspp_pkg::PIN_SCLK];
    wire le_rise = pin_sync[sspp_pkg::PIN_LOAD] & ~pin_prev[sspp_pkg::PIN_LOAD];
    wire ref_tick = pin_sync[sspp_pkg::PIN_REF] & ~pin_prev[sspp_pkg::PIN_REF];
    wire rf_tick = pin_sync[sspp_pkg::PIN_RF] & ~pin_prev[sspp_pkg::PIN_RF];
    wire sdata_s = pin_sync[sspp_pkg::PIN_SDATA];
    wire ce_s = pin_sync[sspp_pkg::PIN_CE];
    wire [sspp_pkg::SHIFT_W-1:0] next_shift = {shift[sspp_pkg::SHIFT_W-2:0], sdata_s};
    wire [1:0] ctrl = shift[sspp_pkg::CTRL_W-1:0];

    // Shift register takes one bit per serial clock rise, oldest bit moving up.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            shift <= sspp_pkg::LATCH_RESET;
        end else if (sclk_rise) begin
            shift <= next_shift;
        end
    end

    // One latch per control code; a strobe edge loads only the addressed one.
    // A strobe that coincides with a clock rise loads the word before that bit.
    for (genvar g = 0; g < sspp_pkg::NUM_LATCH; g++) begin : g_latch
        wire hit = le_rise && (ctrl == 2'(g));
        always_ff @(posedge i_mclk) begin
            if (!i_nrst) begin
                latch[g] <= sspp_pkg::LATCH_RESET;
            end else if (hit) begin
                latch[g] <= shift;
            end
        end
    end

    // Field decode from the latches.
    wire [sspp_pkg::REF_W-1:0] ref_mod =
        latch[sspp_pkg::LATCH_REF][sspp_pkg::REF_LSB +: sspp_pkg::REF_W];
    wire [sspp_pkg::SWALLOW_W-1:0] swallow_val =
        latch[sspp_pkg::LATCH_AB][sspp_pkg::SWALLOW_LSB +: sspp_pkg::SWALLOW_W];
    wire [sspp_pkg::MAIN_W-1:0] main_val =
        latch[sspp_pkg::LATCH_AB][sspp_pkg::MAIN_LSB +: sspp_pkg::MAIN_W];
    wire soft_powerdown_bit = latch[sspp_pkg::LATCH_FUNC][sspp_pkg::PD_BIT];
    wire [sspp_pkg::MUX_W-1:0] mux_sel =
        latch[sspp_pkg::LATCH_FUNC][sspp_pkg::MUX_LSB +: sspp_pkg::MUX_W];
    wire [sspp_pkg::PRE_SEL_W-1:0] pre_sel =
        latch[sspp_pkg::LATCH_FUNC][sspp_pkg::PRE_LSB +: sspp_pkg::PRE_SEL_W];
    wire init_load = le_rise && (ctrl == sspp_pkg::LATCH_INIT);

    // Power-down: chip enable low always wins; high still obeys the soft bit.
    wire next_pd = ~ce_s | soft_powerdown_bit;
    wire counters_clear = o_powered_down | init_load;

    // Reference divider ahead of the phase comparator.
    sspp_divider #(
        .WIDTH(sspp_pkg::REF_W)
    ) u_ref_div (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_clear(counters_clear),
        .i_tick(ref_tick),
        .i_modulus(ref_mod),
        .o_pulse(ref_pulse)
    );

    // Prescaler runs at P+1 while swallow counts remain, else at P.
    wire [sspp_pkg::PRE_CNT_W-1:0] pre_base = sspp_pkg::PRE_BASE << pre_sel;
    wire swallowing = (swallow_left != '0);
    wire [sspp_pkg::PRE_CNT_W-1:0] modulus = pre_base + {6'h00, swallowing};
    wire pre_event = rf_tick && (pcnt == modulus - 1'b1);
    wire main_done = (main_left <= 13'h0001);
    wire [sspp_pkg::PRE_CNT_W-1:0] next_pcnt = pre_event ? '0 : pcnt + 1'b1;

    // Prescaler count of RF edges.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || counters_clear) begin
            pcnt <= '0;
        end else if (rf_tick) begin
            pcnt <= next_pcnt;
        end
    end

    // Swallow and main counters; N = main * P + swallow per feedback pulse.
    // The host must keep swallow at or below main, otherwise the count is not N.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst || counters_clear) begin
            swallow_left <= swallow_val;
            main_left <= main_val;
            fb_pulse <= 1'b0;
        end else begin
            fb_pulse <= pre_event & main_done;
            if (pre_event && main_done) begin
                swallow_left <= swallow_val;
                main_left <= main_val;
            end else if (pre_event) begin
                swallow_left <= swallow_left - {5'h00, swallowing};
                main_left <= main_left - 1'b1;
            end
        end
    end

    // Phase comparator: an edge sets its side, both set together clears both.
    wire up_set = o_pump_up | ref_pulse;
    wire dn_set = o_pump_dn | fb_pulse;
    wire both = up_set & dn_set;
    wire next_up = up_set & ~both;
    wire next_dn = dn_set & ~both;

    // Pump drive and status; o_pump_oe is released together with the power-down flag, up and down drop with it, only lock is held one cycle longer.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_powered_down <= 1'b1;
            o_pump_oe <= 1'b0;
            o_pump_up <= 1'b0;
            o_pump_dn <= 1'b0;
            lock <= 1'b0;
        end else begin
            o_powered_down <= next_pd;
            o_pump_oe <= ~next_pd;
            // Gating with the next power state keeps the pump idle on the very edge it stops.
            o_pump_up <= next_up & ~counters_clear & ~next_pd;
            o_pump_dn <= next_dn & ~counters_clear & ~next_pd;
            lock <= ~counters_clear & ~next_up & ~next_dn;
        end
    end

    // Divided signals are toggled so the observation pin shows a square wave.
    wire [sspp_pkg::MUX_W-1:0] sel = mux_sel;
    wire next_observe = (sel == sspp_pkg::MUX_LOCK) ? lock :
                        (sel == sspp_pkg::MUX_RF_DIV) ? fb_div_q :
                        (sel == sspp_pkg::MUX_REF_DIV) ? ref_div_q : 1'b0;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ref_div_q <= 1'b0;
            fb_div_q <= 1'b0;
            o_observe_mux_output <= 1'b0;
        end else begin
            ref_div_q <= ref_div_q ^ ref_pulse;
            fb_div_q <= fb_div_q ^ fb_pulse;
            o_observe_mux_output <= next_observe;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    a_shift_serial_in: assert property (sclk_rise |=>
        shift == {$past(shift[sspp_pkg::SHIFT_W-2:0]), $past(sdata_s)})
        else $error("shift register did not take the data bit");
    a_func_latch_load: assert property (le_rise && ctrl == sspp_pkg::LATCH_FUNC |=>
        latch[sspp_pkg::LATCH_FUNC] == $past(shift))
        else $error("function latch did not take the shift word");
    a_ref_latch_holds: assert property (le_rise && ctrl != sspp_pkg::LATCH_REF |=>
        $stable(latch[sspp_pkg::LATCH_REF]))
        else $error("reference latch changed on another address");
    a_ab_latch_quiet: assert property (!le_rise |=>
        $stable(latch[sspp_pkg::LATCH_AB]))
        else $error("counter latch changed without a strobe");
    a_ce_forces_pd: assert property (!ce_s |=> o_powered_down && !o_pump_oe)
        else $error("pump still driven with chip enable low");
    a_pd_no_pump: assert property (o_powered_down |->
        !o_pump_up && !o_pump_dn ##1 !o_pump_up)
        else $error("pump active while powered down");
    a_soft_pd_wins: assert property (ce_s && soft_powerdown_bit |=> o_powered_down)
        else $error("soft power-down bit ignored");
    a_powerup_ok: assert property (ce_s && !soft_powerdown_bit |=>
        !o_powered_down ##0 o_pump_oe)
        else $error("device failed to power up");
    a_mux_lock: assert property (sel == sspp_pkg::MUX_LOCK |=>
        o_observe_mux_output == $past(lock))
        else $error("observation output does not show lock");
    a_mux_low: assert property (sel == sspp_pkg::MUX_LOW |=> !o_observe_mux_output)
        else $error("observation output not low when unselected");
    // The wrap is judged on the count register itself, so a late or missed restart shows up.
    a_pre_modulus: assert property (
        rf_tick && pcnt == pre_base + swallowing - 1 |=> pcnt == '0)
        else $error("prescaler wrapped at wrong modulus");
    a_main_reload: assert property (pre_event && main_done && !counters_clear |=>
        fb_pulse && main_left == $past(main_val) && swallow_left == $past(swallow_val))
        else $error("feedback counters did not reload");

    c_load_ab: cover property (le_rise && ctrl == sspp_pkg::LATCH_AB);
    c_fb_pulse: cover property (fb_pulse);
    c_ref_pulse: cover property (ref_pulse ##[1:200] fb_pulse);
    c_power_up: cover property (o_powered_down ##1 !o_powered_down);
    c_load_func: cover property (le_rise && ctrl == sspp_pkg::LATCH_FUNC);
endmodule

// [testbench/sspp_host.sv]
// Host controller model that shifts programming words into the port.
module sspp_host (
    input wire logic i_mclk,
    output logic o_sclk,
    output logic o_sdata,
    output logic o_load_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    // The serial clock stands still low outside frames.
    initial begin
        o_sclk = 1'h0;
        o_sdata = 1'h0;
        o_load_strobe = 1'h0;
    end
    // One word, top bit first, with an 800 ns serial clock; strobe is optional.
    task automatic send(input logic [23:0] word, input bit strobe);
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_mclk);
            o_sdata <= word[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'h1;
            repeat (3) @(posedge i_mclk);
            o_sclk <= 1'h0;
        end
        // The released data line shows the inverse, so a stale bit never looks valid.
        o_sdata <= ~word[0];
        repeat (3) @(posedge i_mclk);
        o_load_strobe <= strobe;
        repeat (3) @(posedge i_mclk);
        o_load_strobe <= 1'h0;
        repeat (3) @(posedge i_mclk);
    endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the synthesizer serial programming port.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int id; logic [15:0] v;} sspp_note_s;
    logic i_mclk, i_nrst, i_chip_enable, i_reference_input, i_rf_feedback_input;
    logic sclk, sdata, strobe, prev_obs;
    logic o_pump_up, o_pump_dn, o_pump_oe, o_powered_down, o_observe_mux_output;
    logic [12:0] b;
    logic [5:0] a;
    logic [13:0] r;
    sspp_note_s q[$];
    sspp_note_s cur;
    int fails, checks, tgl;

    sspp_port DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sclk(sclk), .i_sdata(sdata),
        .i_load_strobe(strobe), .i_chip_enable(i_chip_enable),
        .i_reference_input(i_reference_input), .i_rf_feedback_input(i_rf_feedback_input),
        .o_pump_up(o_pump_up), .o_pump_dn(o_pump_dn), .o_pump_oe(o_pump_oe),
        .o_powered_down(o_powered_down), .o_observe_mux_output(o_observe_mux_output));
    sspp_host u_host (.i_mclk(i_mclk), .o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(strobe));

    // Free-running system clock with a 100 ns period.
    initial begin
        i_mclk = 1'h0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic note(input int id, input logic [15:0] v);
        q.push_back('{id, v});
    endtask

    // Single-bit levels; the four-state compare lets no unknown slip through.
    task automatic cmp_level(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Edge counts seen on the observation output.
    task automatic cmp_count(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Outputs are settled mid-cycle, so every queued note is judged there.
    always @(negedge i_mclk) begin
        while (q.size() > 0) begin
            cur = q.pop_front();
            case (cur.id)
                0: cmp_level("powered_down", cur.v[0], o_powered_down);
                1: cmp_level("pump_oe", cur.v[0], o_pump_oe);
                2: cmp_level("observe", cur.v[0], o_observe_mux_output);
                3: cmp_level("pump_up", cur.v[0], o_pump_up);
                4: cmp_level("pump_dn", cur.v[0], o_pump_dn);
                default: cmp_count("toggles", cur.v, tgl[15:0]);
            endcase
        end
    end

    // Counts edges of the observation output; divided signals toggle once per pulse.
    always @(posedge i_mclk) begin
        if (o_observe_mux_output !== prev_obs) tgl++;
        prev_obs = o_observe_mux_output;
    end

    // A rise every four cycles keeps both pins well inside the synchroniser's reach.
    task automatic pulses(input bit rf, input int n);
        repeat (n) begin
            if (rf) i_rf_feedback_input <= 1'h1;
            else i_reference_input <= 1'h1;
            repeat (2) @(posedge i_mclk);
            i_rf_feedback_input <= 1'h0;
            i_reference_input <= 1'h0;
            repeat (2) @(posedge i_mclk);
        end
    endtask

    function automatic logic [23:0] fw(input logic [1:0] pre, input logic [2:0] mux,
        input logic pd);
        return {pre, 15'h0000, mux, pd, 1'h0, sspp_pkg::LATCH_FUNC};
    endfunction

    // Clears the divider counters and restarts the toggle count.
    task automatic restart();
        u_host.send({22'h000000, sspp_pkg::LATCH_INIT}, 1'b1);
        repeat (4) @(posedge i_mclk);
        tgl = 0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the at most roughly 10500 cycles the sequence needs.
    initial begin
        #5000000;
        fails++;
        tally_and_finish();
    end

    initial begin
        i_nrst = 1'h0;
        i_chip_enable = 1'h0;
        i_reference_input = 1'h0;
        i_rf_feedback_input = 1'h0;
        void'($urandom(91245));
        repeat (10) @(posedge i_mclk);
        i_nrst <= 1'h1;
        repeat (5) @(posedge i_mclk);
        note(0, 16'h0001);
        note(1, 16'h0000);
        i_chip_enable <= 1'h1;
        repeat (5) @(posedge i_mclk);
        note(0, 16'h0000);
        note(1, 16'h0001);
        u_host.send(fw(2'h0, sspp_pkg::MUX_LOW, 1'h1), 1'b1);
        note(0, 16'h0001);
        note(1, 16'h0000);
        u_host.send(fw(2'h0, sspp_pkg::MUX_LOW, 1'h0), 1'b0);
        note(0, 16'h0001);
        u_host.send(fw(2'h0, sspp_pkg::MUX_LOCK, 1'h0), 1'b1);
        note(0, 16'h0000);
        note(2, 16'h0001);
        pulses(1'b0, 1);
        repeat (6) @(posedge i_mclk);
        note(3, 16'h0001);
        note(2, 16'h0000);
        // A feedback pulse meeting a pending up pulse clears both sides.
        pulses(1'b1, 8);
        repeat (6) @(posedge i_mclk);
        note(3, 16'h0000);
        note(4, 16'h0000);
        note(2, 16'h0001);
        i_chip_enable <= 1'h0;
        repeat (5) @(posedge i_mclk);
        note(0, 16'h0001);
        note(1, 16'h0000);
        i_chip_enable <= 1'h1;
        repeat (5) @(posedge i_mclk);
        // Every prescaler pair, with random counters and swallow below main.
        for (int p = 0; p < 4; p++) begin
            b = 13'(2 + $urandom % 4);
            a = 6'($urandom % b);
            u_host.send({3'h0, b, a, sspp_pkg::LATCH_AB}, 1'b1);
            u_host.send(fw(2'(p), sspp_pkg::MUX_RF_DIV, 1'h0), 1'b1);
            restart();
            pulses(1'b1, 2 * (b * (8 << p) + a));
            repeat (8) @(posedge i_mclk);
            note(5, 16'h0002);
            note(4, 16'h0001);
        end
        r = 14'(2 + $urandom % 5);
        u_host.send({8'h00, r, sspp_pkg::LATCH_REF}, 1'b1);
        u_host.send(fw(2'h0, sspp_pkg::MUX_REF_DIV, 1'h0), 1'b1);
        restart();
        pulses(1'b0, 3 * r);
        repeat (8) @(posedge i_mclk);
        note(5, 16'h0003);
        note(3, 16'h0001);
        // Counter latch must have survived the later loads.
        u_host.send(fw(2'h3, sspp_pkg::MUX_RF_DIV, 1'h0), 1'b1);
        restart();
        pulses(1'b1, b * 64 + a);
        repeat (8) @(posedge i_mclk);
        note(5, 16'h0001);
        repeat (2) @(posedge i_mclk);
        tally_and_finish();
    end
endmodule
